// ---- common/crcag_map.svh ----
`ifndef CRCAG_MAP_SVH
`define CRCAG_MAP_SVH

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CRCAG_EN_BIT       0
`define CRCAG_ADDR_RST     16'h0000
`define CRCAG_SEG_RST      4'h0
`define CRCAG_CRC_INIT     16'hFFFF
`define CRCAG_CRC_POLY     16'h1021
`define CRCAG_WORD_STEP    16'h0004
`define CRCAG_LOW_ZERO     2'h0

`endif

// ---- common/crcag_pkg.sv ----
package crcag_pkg;

   // ****************************************************************
   // Automatic walk states
   // ****************************************************************
   typedef enum logic [2:0]
   {
      CRCAG_IDLE  = 3'b001,
      CRCAG_FETCH = 3'b010,
      CRCAG_WAIT  = 3'b100
   } crcag_state_t;

endpackage

// ---- hw/crcag_fold.sv ----
`timescale 1ns/1ns
`include "crcag_map.svh"

// Folds DATA_W bits into a 16-bit CRC, MSB first, one stage per bit
module crcag_fold #(
   parameter int          DATA_W = 16,
   parameter logic [15:0] POLY   = `CRCAG_CRC_POLY
)(
   // Running value and data
   input  wire logic [15:0]       crc_in,
   input  wire logic [DATA_W-1:0] data_in,
   // Folded value
   output logic      [15:0]       crc_out
);
   logic [15:0] chain [0:DATA_W];

   assign chain[0] = crc_in;

   for (genvar i = 0; i < DATA_W; i++)
   begin : g_bit
      logic fb;
      assign fb = chain[i][15] ^ data_in[DATA_W-1-i];
      assign chain[i+1] = {chain[i][14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
   end

   assign crc_out = chain[DATA_W];
endmodule

// ---- hw/crcag_core.sv ----
`timescale 1ns/1ns
`include "crcag_map.svh"

// Functional notes
// - Start address write ignored while automatic enable is set.
// - End address write ignored while automatic enable is set.
// - Start segment write ignored while automatic enable is set.
// - Data input write ignored while automatic enable is set.
// - Result write ignored while automatic enable is set.
// - Automatic walk reads memory in whole four-byte words.
// - Address bits 1 and 0 discarded on write, zero in use.
// - Automatic walk continues or restarts while the processor is halted.
module crcag_core #(
   parameter int ADDR_W = 16,
   parameter int SEG_W  = 4
)(
   // Clock and reset
   input  wire logic              CLOCK,
   input  wire logic              SYS_RST,
   // Software writes
   input  wire logic [15:0]       WDATA,
   input  wire logic              SAD_WE,
   input  wire logic              EAD_WE,
   input  wire logic              SSEG_WE,
   input  wire logic              DATA_WE,
   input  wire logic              RES_WE,
   input  wire logic              MODE_WE,
   // Processor state
   input  wire logic              HALT_REQUEST_BIT,
   // Program memory read port
   output logic                   MEM_RD_REQ,
   output logic [SEG_W+ADDR_W-1:0] MEM_ADDR,
   input  wire logic              MEM_RD_VALID,
   input  wire logic [31:0]       MEM_RDATA,
   // Readback and status
   output logic [ADDR_W-1:0]      AUTO_START_ADDRESS,
   output logic [ADDR_W-1:0]      AUTO_END_ADDRESS,
   output logic [SEG_W-1:0]       AUTO_START_SEGMENT,
   output logic [15:0]            CRC_RESULT_VALUE,
   output logic                   AUTO_CALC_ENABLE,
   output logic                   AUTO_DONE
);
   import crcag_pkg::*;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SYS_RST);

   // ****************************************************************
   // Internal state
   // ****************************************************************
   crcag_state_t      state_reg;
   logic [ADDR_W-1:0] start_reg;
   logic [ADDR_W-1:0] end_reg;
   logic [SEG_W-1:0]  seg_reg;
   logic [ADDR_W-1:0] cur_reg;
   logic [15:0]       res_reg;
   logic              en_reg;
   logic              done_reg;
   logic              req_reg;
   logic [15:0]       fold16;
   logic [15:0]       fold32;
   logic              last_word;
   logic              word_in;
   logic              en_set;

   assign word_in   = (state_reg == CRCAG_WAIT) && MEM_RD_VALID;
   assign last_word = (cur_reg == end_reg);
   assign en_set    = MODE_WE && WDATA[`CRCAG_EN_BIT];

   crcag_fold #(.DATA_W(16)) u_fold_manual
   (
      .crc_in  (res_reg),
      .data_in (WDATA),
      .crc_out (fold16)
   );

   crcag_fold #(.DATA_W(32)) u_fold_auto
   (
      .crc_in  (res_reg),
      .data_in (MEM_RDATA),
      .crc_out (fold32)
   );

   // ****************************************************************
   // Address and segment setup
   // ****************************************************************
   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         start_reg <= `CRCAG_ADDR_RST;
         end_reg   <= `CRCAG_ADDR_RST;
         seg_reg   <= `CRCAG_SEG_RST;
      end
      else
      begin
         if (SAD_WE && !en_reg)
            start_reg <= {WDATA[ADDR_W-1:2], `CRCAG_LOW_ZERO};
         if (EAD_WE && !en_reg)
            end_reg <= {WDATA[ADDR_W-1:2], `CRCAG_LOW_ZERO};
         if (SSEG_WE && !en_reg)
            seg_reg <= WDATA[SEG_W-1:0];
      end
   end

   // ****************************************************************
   // Enable and completion
   // ****************************************************************
   // A software write in the same cycle as the end of the walk wins for the enable,
   // so a fresh enable is never lost; the end of the walk still sets done.
   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         en_reg   <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         if (MODE_WE)
            en_reg <= WDATA[`CRCAG_EN_BIT];
         else if (word_in && last_word)
            en_reg <= 1'b0;
         if (word_in && last_word)
            done_reg <= 1'b1;
         else if (en_set)
            done_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // Automatic walk
   // ****************************************************************
   // The walk pauses between words when the halt drops, keeping its
   // place; a new enable restarts it from the start address.
   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state_reg <= CRCAG_IDLE;
         cur_reg   <= `CRCAG_ADDR_RST;
         req_reg   <= 1'b0;
      end
      else
      begin
         req_reg <= 1'b0;
         if (en_set && !en_reg)
            cur_reg <= start_reg;
         case (state_reg)
            CRCAG_IDLE:
            begin
               if (en_reg && HALT_REQUEST_BIT && !MODE_WE)
               begin
                  req_reg   <= 1'b1;
                  state_reg <= CRCAG_FETCH;
               end
            end
            CRCAG_FETCH:
               state_reg <= CRCAG_WAIT;
            CRCAG_WAIT:
            begin
               if (MEM_RD_VALID)
               begin
                  state_reg <= CRCAG_IDLE;
                  if (!last_word)
                     cur_reg <= ADDR_W'(cur_reg + `CRCAG_WORD_STEP);
               end
            end
            default:
               state_reg <= CRCAG_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Running CRC
   // ****************************************************************
   always_ff @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
         res_reg <= `CRCAG_CRC_INIT;
      else if (word_in)
         res_reg <= fold32;
      else if (RES_WE && !en_reg)
         res_reg <= WDATA;
      else if (DATA_WE && !en_reg)
         res_reg <= fold16;
   end

   assign MEM_RD_REQ         = req_reg;
   assign MEM_ADDR           = {seg_reg, cur_reg};
   assign AUTO_START_ADDRESS = start_reg;
   assign AUTO_END_ADDRESS   = end_reg;
   assign AUTO_START_SEGMENT = seg_reg;
   assign CRC_RESULT_VALUE   = res_reg;
   assign AUTO_CALC_ENABLE   = en_reg;
   assign AUTO_DONE          = done_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_locked_write(we);
      we && en_reg;
   endsequence

   sequence s_fetch;
      MEM_RD_REQ ##1 (state_reg == CRCAG_WAIT);
   endsequence

   property p_sad_hold;
      s_locked_write(SAD_WE) |=> $stable(start_reg);
   endproperty
   a_sad_hold: assert property (p_sad_hold) else $error("start address changed while locked");

   property p_ead_hold;
      s_locked_write(EAD_WE) |=> $stable(end_reg);
   endproperty
   a_ead_hold: assert property (p_ead_hold) else $error("end address changed while locked");

   property p_seg_hold;
      s_locked_write(SSEG_WE) |=> $stable(seg_reg);
   endproperty
   a_seg_hold: assert property (p_seg_hold) else $error("segment changed while locked");

   property p_data_ignored;
      s_locked_write(DATA_WE && !word_in) |=> $stable(res_reg);
   endproperty
   a_data_ignored: assert property (p_data_ignored) else $error("data write taken while locked");

   property p_res_ignored;
      s_locked_write(RES_WE && !word_in) |=> $stable(res_reg);
   endproperty
   a_res_ignored: assert property (p_res_ignored) else $error("result write taken while locked");

   property p_word_step;
      word_in && !last_word && !(en_set && !en_reg)
         |=> cur_reg == $past(cur_reg) + `CRCAG_WORD_STEP;
   endproperty
   a_word_step: assert property (p_word_step) else $error("walk did not step four bytes");

   property p_low_zero;
      start_reg[1:0] == `CRCAG_LOW_ZERO && end_reg[1:0] == `CRCAG_LOW_ZERO
         && MEM_ADDR[1:0] == `CRCAG_LOW_ZERO;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("low address bits not zero");

   property p_halt_fetch;
      (state_reg == CRCAG_IDLE) && en_reg && HALT_REQUEST_BIT && !MODE_WE
         |=> s_fetch;
   endproperty
   a_halt_fetch: assert property (p_halt_fetch) else $error("walk did not run in halt");

   property p_data_fold;
      DATA_WE && !en_reg && !RES_WE && !word_in |=> res_reg == $past(fold16);
   endproperty
   a_data_fold: assert property (p_data_fold) else $error("data write not folded");
endmodule

// ---- sim/crcag_core_tb.sv ----
`timescale 1ns/1ns

module crcag_core_tb;

   // **********
   // Stimulus
   // **********
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [15:0] wdata = 16'h0000;
   logic [5:0]  we = 6'h00;
   logic        halt = 1'b0;
   logic        valid = 1'b0;
   logic [31:0] rdata = 32'h00000000;
   logic        req;
   logic        en;
   logic        done;
   logic [19:0] maddr;
   logic [15:0] sad;
   logic [15:0] ead;
   logic [15:0] res;
   logic [3:0]  seg;
   logic [15:0] crc;
   int          fail_count = 0;
   int          samples_checked = 0;

   always #5 clock = ~clock;

   crcag_core i_crcag_core (
      .CLOCK              (clock),
      .SYS_RST            (sys_rst),
      .WDATA              (wdata),
      .SAD_WE             (we[0]),
      .EAD_WE             (we[1]),
      .SSEG_WE            (we[2]),
      .DATA_WE            (we[3]),
      .RES_WE             (we[4]),
      .MODE_WE            (we[5]),
      .HALT_REQUEST_BIT   (halt),
      .MEM_RD_REQ         (req),
      .MEM_ADDR           (maddr),
      .MEM_RD_VALID       (valid),
      .MEM_RDATA          (rdata),
      .AUTO_START_ADDRESS (sad),
      .AUTO_END_ADDRESS   (ead),
      .AUTO_START_SEGMENT (seg),
      .CRC_RESULT_VALUE   (res),
      .AUTO_CALC_ENABLE   (en),
      .AUTO_DONE          (done)
   );

   // **********
   // Helpers
   // **********
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task finish_test;
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Reference fold, MSB first, kept apart from the design's own
   function automatic logic [15:0] fold(input logic [15:0] c, input logic [31:0] d,
                                        input int n);
      logic fb;
      for (int b = n - 1; b >= 0; b--)
      begin
         fb = c[15] ^ d[b];
         c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction

   task automatic wr(input int i, input logic [15:0] d);
      @(posedge clock);
      #1;
      we[i] = 1'b1;
      wdata = d;
      @(posedge clock);
      #1;
      we[i] = 1'b0;
   endtask

   // Answers one fetch; p drops halt together with the word
   task automatic word(input logic [15:0] a, input logic [31:0] d, input logic p);
      int n;
      n = 0;
      while (req !== 1'b1)
      begin
         @(posedge clock);
         #1;
         n++;
         if (n > 50)
         begin
            fail_count++;
            finish_test();
         end
      end
      chk(maddr, {4'h5, a});
      @(posedge clock);
      #1;
      valid = 1'b1;
      rdata = d;
      halt = ~p;
      @(posedge clock);
      #1;
      valid = 1'b0;
      crc = fold(crc, d, 32);
      chk(res, crc);
   endtask

   initial
   begin
      repeat (12) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      chk({sad, seg}, 20'h00000);
      chk(ead, 16'h0000);
      chk(res, 16'hFFFF);
      chk({en, done}, 2'b00);
      wr(0, 16'h1237);
      chk(sad, 16'h1234);
      wr(1, 16'h123B);
      chk(ead, 16'h1238);
      wr(2, 16'h0005);
      chk(seg, 4'h5);
      wr(3, 16'h1234);
      crc = fold(16'hFFFF, 32'h00001234, 16);
      chk(res, crc);
      wr(4, 16'hABCD);
      chk(res, 16'hABCD);
      wr(5, 16'h0001);
      chk(en, 1'b1);
      // Locked writes while enabled, halt low so no fetch yet
      for (int i = 0; i < 5; i++)
         wr(i, 16'hFFFF);
      chk(sad, 16'h1234);
      chk(ead, 16'h1238);
      chk(seg, 4'h5);
      chk(res, 16'hABCD);
      crc = 16'hABCD;
      halt = 1'b1;
      word(16'h1234, 32'hDEADBEEF, 1'b1);
      repeat (4)
      begin
         @(posedge clock);
         #1;
         chk(req, 1'b0);
      end
      // Manual use in mid-walk: unlock, fold, restore saved result, re-enable
      wr(5, 16'h0000);
      chk(en, 1'b0);
      wr(3, 16'h5A5A);
      chk(res, fold(crc, 32'h00005A5A, 16));
      wr(4, crc);
      wr(5, 16'h0001);
      chk(res, crc);
      // Re-enable restarts the walk from the start address
      halt = 1'b1;
      word(16'h1234, 32'h89ABCDEF, 1'b0);
      halt = 1'b1;
      word(16'h1238, 32'h0F1E2D3C, 1'b0);
      chk({en, done}, 2'b01);
      wr(5, 16'h0001);
      chk({en, done}, 2'b10);
      word(16'h1234, 32'h01234567, 1'b0);
      finish_test();
   end

endmodule
